// >>> rtl/dual_dac_pkg.sv
// shared constants for the dual converter serial loader
package dual_dac_pkg;
  localparam int          word_bits      = 16;   // command word length
  localparam int          data_bits      = 8;    // data byte width
  localparam int          load_a_pos     = 8;    // load channel a flag
  localparam int          load_b_pos     = 9;    // load channel b flag
  localparam int          spare_4_pos    = 10;   // uncommitted, host sends 0
  localparam int          shut_a_pos     = 11;   // shutdown channel a flag
  localparam int          shut_b_pos     = 12;   // shutdown channel b flag
  localparam int          spare_3_pos    = 13;   // uncommitted, host sends 1
  localparam int          sync_stages    = 2;    // pin synchroniser depth
  localparam logic [15:0] word_reset     = 16'h0000; // shift register clear
  localparam logic [7:0]  data_reset     = 8'h00;    // model reset data value
  localparam logic        shut_reset     = 1'b1;     // model reset: shut down
  localparam int          core_clk_mhz   = 20;   // core clock rate
  localparam int          max_sclk_mhz   = 5;    // fastest serial clock
  // state of the frame tracker
  typedef enum logic [1:0]
  {
    st_idle  = 2'b00,
    st_frame = 2'b01
  } frame_e;
endpackage : dual_dac_pkg

// >>> rtl/pin_sync.sv
// two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import dual_dac_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic init_level,
  input  wire logic pin_in,
  output logic      pin_sync_out
);
  // synchroniser flops, first only feeds the second
  typedef struct packed
  {
    logic meta;   // first stage
    logic sync;   // second stage
  } sync_s;
  sync_s st;       // registered state
  sync_s next_st;  // next state

  ////////////////////////////////////////////////////////////////////////
  // next value
  always_comb
  begin
    next_st      = st;
    next_st.meta = pin_in;
    next_st.sync = st.meta;
  end

  // register, frozen while enable is low
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign pin_sync_out = st.sync;
  // init_level unused in reset since reset must be constant
  logic unused_init;
  assign unused_init = init_level;
endmodule : pin_sync
`default_nettype wire

// >>> rtl/channel_out.sv
// one converter channel: data hold and output enable with shutdown
`timescale 1ns/1ps
`default_nettype none
module channel_out
  import dual_dac_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 clk_en,
  input  wire logic                 apply,
  input  wire logic                 load_bit,
  input  wire logic                 shut_bit,
  input  wire logic [data_bits-1:0] data_byte,
  output logic [data_bits-1:0]      code,
  output logic                      out_en_n,
  output logic                      ref_connected
);
  // channel state
  typedef struct packed
  {
    logic [data_bits-1:0] code;  // stored data register
    logic                 shut;  // shutdown state
  } chan_s;
  chan_s st;       // registered state
  chan_s next_st;  // next state

  ////////////////////////////////////////////////////////////////////////
  // load and shutdown act independently on the command edge
  always_comb
  begin
    next_st = st;
    if (apply)
    begin
      if (load_bit)
        next_st.code = data_byte;      // RULE8
      next_st.shut = shut_bit;         // RULE12
    end
  end

  // register; reset value only a model stand-in, device has none
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st.code <= data_reset;           // RULE19
      st.shut <= shut_reset;
    end
    else if (clk_en)
      st <= next_st;
  end

  // output code kept through shutdown, only the enable and the reference connection drop
  assign code          = st.code;      // RULE15
  assign out_en_n      = st.shut;      // RULE14
  assign ref_connected = ~st.shut;     // RULE14
endmodule : channel_out
`default_nettype wire

// >>> rtl/dual_dac_serial_loader.sv
// serial command loader of a dual 8-bit voltage-output converter
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1 - shift only while chip select is low
// RULE2 - shift data on each serial clock rise
// RULE3 - host keeps serial clock at most 5MHz
// RULE4 - sixteen bits msb first, control then data
// RULE5 - shifting continues across gaps with select low
// RULE6 - apply command on chip select rising edge
// RULE7 - every control bit acts on its own
// RULE8 - load a copies data into channel a
// RULE9 - load b copies data into channel b
// RULE10 - both channels share one data byte
// RULE11 - no load flags leaves registers alone
// RULE12 - shutdown a flag sets channel a state
// RULE13 - shutdown b flag sets channel b state
// RULE14 - shutdown floats output and isolates reference
// RULE15 - shutdown keeps stored data, restores on exit
// RULE16 - load and shutdown act in same word
// RULE17 - host sends spare three one, four zero
// RULE18 - straight binary code, output ref times d/256
// RULE19 - no power-on reset, state undefined; model reset loads data 0, shut down
// RULE20 - host writes both channels after power-up
// RULE21 - host uses clock idle low, mode zero
// RULE22 - host toggles clock only when sending; the bench host noise task also toggles it while deselected
// RULE23 - apply the last sixteen bits shifted
module dual_dac_serial_loader
  import dual_dac_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 clk_en,
  input  wire logic                 chip_select_n,
  input  wire logic                 serial_clock_pin,
  input  wire logic                 serial_data_pin,
  output logic [data_bits-1:0]      channel_a_code,
  output logic [data_bits-1:0]      channel_b_code,
  output logic                      channel_a_output_en_n,
  output logic                      channel_b_output_en_n,
  output logic                      channel_a_ref_connected,
  output logic                      channel_b_ref_connected,
  output logic                      command_applied,
  output logic [word_bits-1:0]      serial_command_word
);
  // serial clock must be slow enough for the core to see both edges
  localparam int min_core_per_sclk = core_clk_mhz / max_sclk_mhz; // RULE3

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic cs_n_s;   // synchronised chip select
  logic sclk_s;   // synchronised serial clock
  logic din_s;    // synchronised serial data

  pin_sync u_sync_cs
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .init_level   (1'b1),
    .pin_in       (chip_select_n),
    .pin_sync_out (cs_n_s)
  );

  pin_sync u_sync_sclk
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .init_level   (1'b0),
    .pin_in       (serial_clock_pin),
    .pin_sync_out (sclk_s)
  );

  pin_sync u_sync_din
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .init_level   (1'b0),
    .pin_in       (serial_data_pin),
    .pin_sync_out (din_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // block state
  typedef struct packed
  {
    frame_e               state;    // idle or in frame
    logic                 sclk_d;   // delayed serial clock for edge find
    logic                 cs_n_d;   // delayed chip select for edge find
    logic [word_bits-1:0] shift;    // input shift register
    logic                 apply;    // one-cycle command strobe
    logic [sync_stages-1:0] settle; // pin synchronisers filled since reset
  } top_s;
  top_s st;       // registered state
  top_s next_st;  // next state

  logic sclk_rise;   // serial clock rising edge
  logic cs_rise;     // chip select rising edge

  assign sclk_rise = sclk_s & ~st.sclk_d;
  assign cs_rise   = cs_n_s & ~st.cs_n_d;

  ////////////////////////////////////////////////////////////////////////
  // frame tracking and shifting
  always_comb
  begin
    next_st        = st;
    next_st.sclk_d = sclk_s;
    next_st.cs_n_d = cs_n_s;
    next_st.apply  = 1'b0;
    // ones walk up as the synchroniser pipes fill after reset
    next_st.settle = {st.settle[sync_stages-2:0], 1'b1};
    case (st.state)
      st_idle:
      begin
        // clock activity ignored while deselected; synchronisers reset
        // to zero, so chip select only counts once their pipes are full
        if (!cs_n_s && st.settle[sync_stages-1])             // RULE1
          next_st.state = st_frame;
      end
      st_frame:
      begin
        if (cs_rise)
        begin
          // command edge: use last sixteen bits
          next_st.apply = 1'b1;                              // RULE6 RULE23
          next_st.state = st_idle;
        end
        else if (sclk_rise)
          // msb first, new bit enters at the bottom; gaps just wait
          next_st.shift = {st.shift[word_bits-2:0], din_s};  // RULE2 RULE4 RULE5
      end
      default:
        next_st.state = st_idle;
    endcase
  end

  // register, frozen while enable is low
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st.state  <= st_idle;
      st.sclk_d <= 1'b0;
      st.cs_n_d <= 1'b1;
      st.shift  <= word_reset;
      st.apply  <= 1'b0;
      st.settle <= '0;
    end
    else if (clk_en)
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // channels: shared data byte, independent flags
  logic [data_bits-1:0] data_byte;   // low byte of the word
  assign data_byte = st.shift[data_bits-1:0];                // RULE10 RULE18

  channel_out u_chan_a
  (
    .core_clk      (core_clk),
    .arst_n        (arst_n),
    .clk_en        (clk_en),
    .apply         (st.apply),
    .load_bit      (st.shift[load_a_pos]),                   // RULE7 RULE11
    .shut_bit      (st.shift[shut_a_pos]),                   // RULE16
    .data_byte     (data_byte),
    .code          (channel_a_code),
    .out_en_n      (channel_a_output_en_n),
    .ref_connected (channel_a_ref_connected)
  );

  channel_out u_chan_b
  (
    .core_clk      (core_clk),
    .arst_n        (arst_n),
    .clk_en        (clk_en),
    .apply         (st.apply),
    .load_bit      (st.shift[load_b_pos]),                   // RULE9
    .shut_bit      (st.shift[shut_b_pos]),                   // RULE13
    .data_byte     (data_byte),
    .code          (channel_b_code),
    .out_en_n      (channel_b_output_en_n),
    .ref_connected (channel_b_ref_connected)
  );

  // visibility of the word and the strobe
  assign command_applied     = st.apply;
  assign serial_command_word = st.shift;
endmodule : dual_dac_serial_loader
`default_nettype wire

// >>> dv/host_model.sv
// host side model: drives the three serial pins
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input  wire logic core_clk,
  output logic      chip_select_n,
  output logic      serial_clock_pin,
  output logic      serial_data_pin
);
  // idle: deselected, clock low
  initial
  begin
    {chip_select_n, serial_clock_pin, serial_data_pin} = 3'h4;
  end
  // wait n falling core edges
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  // one word msb first, 400 ns bit time, optional mid gap
  task automatic send(input logic [15:0] w, input logic split);
    chip_select_n = 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_pin = w[i];
      tick(4);
      serial_clock_pin = 1'b1;
      tick(4);
      serial_clock_pin = 1'b0;
      if (split && i == 8) tick(12);
    end
    serial_data_pin = ~w[0]; // stale data no longer valid
    tick(3);
    chip_select_n = 1'b1;
    tick(10);
  endtask : send
  // clocks and data toggling while deselected
  task automatic noise();
    for (int i = 0; i < 8; i++)
    begin
      serial_data_pin = ~serial_data_pin;
      serial_clock_pin = ~serial_clock_pin;
      tick(4);
    end
  endtask : noise
endmodule : host_model
`default_nettype wire

// >>> dv/dual_dac_checker_properties.sv
// concurrent checks on the loader ports
`timescale 1ns/1ps
`default_nettype none
module dual_dac_checker
  import dual_dac_pkg::*;
(
  input wire logic core_clk, arst_n, clk_en, chip_select_n, command_applied,
  input wire logic [data_bits-1:0] channel_a_code, channel_b_code,
  input wire logic channel_a_output_en_n, channel_b_output_en_n,
  input wire logic channel_a_ref_connected, channel_b_ref_connected,
  input wire logic [word_bits-1:0] serial_command_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_pulse; command_applied |=> !command_applied; endproperty
  property p_apply; $rose(chip_select_n) && clk_en |->
    ##[1:8] command_applied; endproperty
  property p_load_a; command_applied |=> channel_a_code ==
    ($past(serial_command_word[load_a_pos]) ?
     $past(serial_command_word[7:0]) : $past(channel_a_code)); endproperty
  property p_load_b; command_applied |=> channel_b_code ==
    ($past(serial_command_word[load_b_pos]) ?
     $past(serial_command_word[7:0]) : $past(channel_b_code)); endproperty
  property p_shut_a; command_applied |=>
    channel_a_output_en_n == $past(serial_command_word[shut_a_pos]);
  endproperty
  property p_shut_b; command_applied |=>
    channel_b_output_en_n == $past(serial_command_word[shut_b_pos]);
  endproperty
  property p_hold; !$past(command_applied) |-> $stable({channel_a_code,
    channel_b_code, channel_a_output_en_n, channel_b_output_en_n});
  endproperty
  property p_ref; channel_a_ref_connected == !channel_a_output_en_n &&
    channel_b_ref_connected == !channel_b_output_en_n; endproperty
  property p_quiet; chip_select_n [*4] |=> $stable(serial_command_word);
  endproperty
  property p_shift; $changed(serial_command_word) |->
    serial_command_word[15:1] == $past(serial_command_word[14:0]);
  endproperty
  a_pulse: assert property (p_pulse) else $error("apply not a pulse");
  a_apply: assert property (p_apply) else $error("no apply");
  a_load_a: assert property (p_load_a) else $error("a load");
  a_load_b: assert property (p_load_b) else $error("b load");
  a_shut_a: assert property (p_shut_a) else $error("a shut");
  a_shut_b: assert property (p_shut_b) else $error("b shut");
  a_hold: assert property (p_hold) else $error("early change");
  a_ref: assert property (p_ref) else $error("ref state");
  a_quiet: assert property (p_quiet) else $error("shift deselected");
  a_shift: assert property (p_shift) else $error("bad shift");
  c_both: cover property (command_applied && serial_command_word[9:8] == 2'h3);
  c_shut: cover property (channel_a_output_en_n && channel_b_output_en_n);
  c_shift: cover property ($changed(serial_command_word));
endmodule : dual_dac_checker
bind dual_dac_serial_loader dual_dac_checker u_chk (.core_clk(core_clk),
  .arst_n(arst_n), .clk_en(clk_en), .chip_select_n(chip_select_n),
  .command_applied(command_applied), .channel_a_code(channel_a_code),
  .channel_b_code(channel_b_code),
  .channel_a_output_en_n(channel_a_output_en_n),
  .channel_b_output_en_n(channel_b_output_en_n),
  .channel_a_ref_connected(channel_a_ref_connected),
  .channel_b_ref_connected(channel_b_ref_connected),
  .serial_command_word(serial_command_word));
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench of the dual converter loader
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dual_dac_pkg::*;
;
  logic        core_clk = 1'b0, arst_n = 1'b0, cs_n, sclk, din, ap, sa, sb;
  logic [7:0]  a_code, b_code, exp_a, exp_b;
  logic        en = 1'b1;  // core clock enable
  wire  [3:0]  st;
  logic [15:0] word, w;
  int          failures = 0, n_compared = 0;
  always #25 core_clk = ~core_clk;
  dual_dac_serial_loader dut (.core_clk(core_clk), .arst_n(arst_n),
    .clk_en(en), .chip_select_n(cs_n), .serial_clock_pin(sclk),
    .serial_data_pin(din), .channel_a_code(a_code), .channel_b_code(b_code),
    .channel_a_output_en_n(st[3]), .channel_b_output_en_n(st[2]),
    .channel_a_ref_connected(st[1]), .channel_b_ref_connected(st[0]),
    .command_applied(ap), .serial_command_word(word));
  host_model host (.core_clk(core_clk), .chip_select_n(cs_n),
    .serial_clock_pin(sclk), .serial_data_pin(din));
  // next data register value
  function automatic logic [7:0] nxt(input logic l, input logic [7:0] o, d);
    return l ? d : o;
  endfunction : nxt
  // word from flags {shut b, shut a, load b, load a} and data
  function automatic logic [15:0] mk(input logic [3:0] f, input logic [7:0] d);
    return {2'($urandom), 1'b1, f[3], f[2], 1'b0, f[1], f[0], d};
  endfunction : mk
  task automatic cmp(input logic [7:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // send one command and check every output except command_applied
  task automatic run(input logic [15:0] c, input logic split);
    host.send(c, split);
    exp_a = nxt(c[load_a_pos], exp_a, c[7:0]);
    exp_b = nxt(c[load_b_pos], exp_b, c[7:0]);
    {sb, sa} = {c[shut_b_pos], c[shut_a_pos]};
    cmp(a_code, exp_a);
    cmp(b_code, exp_b);
    cmp(8'(st), {4'h0, sa, sb, ~sa, ~sb});
    cmp(word[15:8], c[15:8]);
    cmp(word[7:0], c[7:0]);
  endtask : run
  task automatic test_done();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // main sequence: init, all flag combinations, deselected clocks
  initial
  begin
    void'($urandom(32'h69ee7a10));
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    {exp_a, exp_b} = {data_reset, data_reset};
    run(mk(4'h3, 8'h80), 1'b0);
    $display("test init done");
    for (int i = 0; i < 24; i++)
    begin
      w = mk(i < 16 ? 4'(i) : 4'($urandom), i < 2 ? 8'(i * 255) : 8'($urandom));
      run(w, 1'(i));
      $display("test %0d done", i);
    end
    host.noise();
    cmp(a_code, exp_a);
    cmp(word[7:0], w[7:0]);
    $display("test noise done");
    // whole frame sent while frozen: nothing may change
    en = 1'b0;
    host.send(mk(4'hf, ~exp_a), 1'b0);
    en = 1'b1;
    host.tick(4);
    cmp(a_code, exp_a);
    cmp(b_code, exp_b);
    cmp(8'(st), {4'h0, sa, sb, ~sa, ~sb});
    cmp(word[7:0], w[7:0]);
    $display("test freeze done");
    test_done();
  end
  // watchdog
  initial
  begin
    #2_000_000;
    failures++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
